// file: cfr_core.v
// cfr_core.v: register state, status word and result flags of the core.
// Assumes an APB master on the clock domain of clk_sys, and an interrupt
// source that drops its request once it sees intAccept.
`timescale 1ns/1ps
`default_nettype none
`include "cfr_regs.vh"
module cfr_core #(
	parameter DW = 16,
	parameter NGPR = 8,
	parameter NSEG = 4
) (
	// Clock and reset.
	input wire clk_sys,
	input wire nrst,
	// APB slave.
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Maskable interrupt.
	input wire intReq,
	input wire [15:0] intVector,
	// Core events and modes.
	output wire intAccept,
	output wire stepTrap,
	output wire stringDown
);
	// ----------------------------------------
	// State and declarations.
	// ----------------------------------------
	reg pready_q;
	reg pslverr_q;
	reg [31:0] prdata_q;
	reg [31:0] rdData;
	reg [15:0] flags_q;
	reg [15:0] ip_q;
	reg [31:0] aluCmd_q;
	reg [31:0] eaCtrl_q;
	reg intAccept_q;
	reg stepTrap_q;
	reg stringDown_q;
	reg gaEn;
	reg [2:0] gaIdx;
	reg gaLo;
	reg gaHi;
	reg [15:0] gaData;
	reg [15:0] eaBase;
	wire [NGPR*DW-1:0] gprAll;
	wire [NSEG*DW-1:0] segAll;
	wire [15:0] fuRes;
	wire fuCarry;
	wire fuParity;
	wire fuAux;
	wire fuZero;
	wire fuSign;
	wire fuOvfl;
	wire fuUpd;
	wire fuKeepCarry;
	wire fuWb;

	// ----------------------------------------
	// Bus decode.
	// ----------------------------------------
	// The slave answers with one wait-free access phase; pready comes from a flop.
	wire apbSetup = psel & ~penable;
	wire apbWr = psel & penable & pready_q & pwrite;
	wire aligned = (paddr[1:0] == `CFR_ALIGN);
	wire mapped = aligned && (paddr <= `CFR_OFF_LAST);
	wire gprHit = aligned && (paddr < `CFR_OFF_SEG);
	wire segHit = aligned && (paddr >= `CFR_OFF_SEG) && (paddr < `CFR_OFF_IP);
	wire [2:0] gprIdx = paddr[4:2];
	wire [1:0] segIdx = paddr[3:2];
	wire wrGpr = apbWr & gprHit;
	wire wrSeg = apbWr & segHit;
	wire wrIp = apbWr & (paddr == `CFR_OFF_IP);
	wire wrFlags = apbWr & (paddr == `CFR_OFF_FLAGS);
	wire wrAlu = apbWr & (paddr == `CFR_OFF_ALU);
	wire wrEa = apbWr & (paddr == `CFR_OFF_EA);
	wire wrStr = apbWr & (paddr == `CFR_OFF_STR);
	wire wrAdv = apbWr & (paddr == `CFR_OFF_ADV);

	// Word of a general register by index. The register file is passed in, so that
	// every caller is re-evaluated when any register changes, not only its index.
	function [15:0] gprWord;
		input [NGPR*DW-1:0] all;
		input [2:0] idx;
		begin
			gprWord = all[idx*DW +: DW];
		end
	endfunction

	// Operand by register code; byte codes pick a half of the first four words.
	function [15:0] operand;
		input [NGPR*DW-1:0] all;
		input [2:0] code;
		input byteMode;
		reg [15:0] w;
		begin
			w = gprWord(all, byteMode ? {1'b0, code[`CFR_BR_WORD]} : code);
			operand = w;
			if (byteMode)
				operand = code[`CFR_BR_HI] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
		end
	endfunction

	// ----------------------------------------
	// Arithmetic command operands.
	// ----------------------------------------
	wire [2:0] aluDst = pwdata[`CFR_F_DST];
	wire [2:0] aluSrc = pwdata[`CFR_F_SRC];
	wire aluByte = pwdata[`CFR_F_BYTE];
	wire [15:0] aluA = operand(gprAll, aluDst, aluByte);
	wire [15:0] aluB = operand(gprAll, aluSrc, aluByte);

	cfr_flag_unit uFlag (
		.opA(aluA),
		.opB(aluB),
		.carryIn(flags_q[`CFR_CARRY]),
		.opCode(pwdata[`CFR_F_OPC]),
		.byteMode(aluByte),
		.result(fuRes),
		.carryOut(fuCarry),
		.parityOut(fuParity),
		.auxOut(fuAux),
		.zeroOut(fuZero),
		.signOut(fuSign),
		.ovflOut(fuOvfl),
		.updFlags(fuUpd),
		.keepCarry(fuKeepCarry),
		.writeBack(fuWb)
	);

	// ----------------------------------------
	// String index stepping.
	// ----------------------------------------
	wire [15:0] stepAmt = pwdata[`CFR_F_SWORD] ? `CFR_STEP_WORD : `CFR_STEP_BYTE;
	wire [15:0] srcIdx = gprWord(gprAll, `CFR_R_SIDX);
	wire [15:0] dstIdx = gprWord(gprAll, `CFR_R_DIDX);
	wire [15:0] srcNext = flags_q[`CFR_DIR] ? srcIdx - stepAmt : srcIdx + stepAmt;
	wire [15:0] dstNext = flags_q[`CFR_DIR] ? dstIdx - stepAmt : dstIdx + stepAmt;

	// ----------------------------------------
	// General register write port A.
	// ----------------------------------------
	// Bus writes win over the command engine; both come from one bus access.
	always @* begin
		gaEn = 1'b0;
		gaIdx = gprIdx;
		gaLo = 1'b1;
		gaHi = 1'b1;
		gaData = pwdata[15:0];
		if (wrGpr) begin
			gaEn = 1'b1;
		end else if (wrAlu && fuWb) begin
			// byte result lands in one half.
			gaEn = 1'b1;
			gaIdx = aluByte ? {1'b0, aluDst[`CFR_BR_WORD]} : aluDst;
			gaLo = ~aluByte | ~aluDst[`CFR_BR_HI];
			gaHi = ~aluByte | aluDst[`CFR_BR_HI];
			gaData = aluByte ? {fuRes[7:0], fuRes[7:0]} : fuRes;
		end else if (wrStr) begin
			gaEn = 1'b1;
			gaIdx = `CFR_R_SIDX;
			gaData = srcNext;
		end
	end

	cfr_gpr_file #(
		.DW(DW),
		.NREG(NGPR),
		.IW(3)
	) uGpr (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.aEn(gaEn),
		.aIdx(gaIdx),
		.aLo(gaLo),
		.aHi(gaHi),
		.aData(gaData),
		.bEn(wrStr),
		.bIdx(`CFR_R_DIDX),
		.bData(dstNext),
		.rdAll(gprAll)
	);

	// ----------------------------------------
	// Segment registers.
	// ----------------------------------------
	genvar s;
	generate
		for (s = 0; s < NSEG; s = s + 1) begin : gSeg
			reg [DW-1:0] seg_q;
			always @(posedge clk_sys) begin
				if (!nrst)
					seg_q <= `CFR_REG_RST;
				else if (wrSeg && {30'h0000_0000, segIdx} == s)
					seg_q <= pwdata[DW-1:0];
			end
			assign segAll[s*DW +: DW] = seg_q;
		end
	endgenerate

	// ----------------------------------------
	// Operand offset and physical address.
	// ----------------------------------------
	wire [15:0] baseW = gprWord(gprAll, `CFR_R_BASE);
	wire [15:0] bptrW = gprWord(gprAll, `CFR_R_BPTR);
	wire [1:0] eaSeg = eaCtrl_q[`CFR_F_EASEG];
	wire [15:0] segW = segAll[eaSeg*DW +: DW];
	wire [15:0] eaOff = eaBase + eaCtrl_q[`CFR_F_DISP];
	wire [19:0] physAddr = {segW, `CFR_SEG_PAD} + {`CFR_SEG_PAD, eaOff};

	always @* begin
		case (eaCtrl_q[`CFR_F_EAMODE])
			`CFR_EA_BSI: eaBase = baseW + srcIdx;
			`CFR_EA_BDI: eaBase = baseW + dstIdx;
			`CFR_EA_PSI: eaBase = bptrW + srcIdx;
			`CFR_EA_PDI: eaBase = bptrW + dstIdx;
			`CFR_EA_SI: eaBase = srcIdx;
			`CFR_EA_DI: eaBase = dstIdx;
			`CFR_EA_B: eaBase = baseW;
			default: eaBase = `CFR_REG_RST;
		endcase
	end

	// ----------------------------------------
	// Status word.
	// ----------------------------------------
	// A bus write replaces every defined bit; commands update only their flags.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			flags_q <= `CFR_FLAGS_RST;
		end else if (wrFlags) begin
			flags_q <= pwdata[15:0] & `CFR_FLAGS_MASK;
		end else begin
			if (wrAlu && fuUpd) begin
				if (!fuKeepCarry)
					flags_q[`CFR_CARRY] <= fuCarry;
				flags_q[`CFR_PARITY] <= fuParity;
				flags_q[`CFR_AUXC] <= fuAux;
				flags_q[`CFR_ZERO] <= fuZero;
				flags_q[`CFR_SIGN] <= fuSign;
				flags_q[`CFR_OVFL] <= fuOvfl;
			end
			if (wrAdv && flags_q[`CFR_STEP])
				flags_q[`CFR_STEP] <= 1'b0;
		end
	end

	// ----------------------------------------
	// Instruction pointer and events.
	// ----------------------------------------
	// An interrupt waits out any bus write so the pointer has one source per cycle.
	// enable flag gates vectoring.
	wire intTake = intReq & flags_q[`CFR_INTEN] & ~apbWr & ~intAccept_q;

	always @(posedge clk_sys) begin
		if (!nrst)
			ip_q <= `CFR_REG_RST;
		else if (wrIp)
			ip_q <= pwdata[15:0];
		else if (wrAdv)
			ip_q <= ip_q + {`CFR_LEN_PAD, pwdata[`CFR_F_LEN]};
		else if (intTake)
			ip_q <= intVector;
	end

	// Event pulses and mode level, all registered.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			intAccept_q <= 1'b0;
			stepTrap_q <= 1'b0;
			stringDown_q <= 1'b0;
		end else begin
			intAccept_q <= intTake;
			stepTrap_q <= wrAdv & flags_q[`CFR_STEP];
			stringDown_q <= flags_q[`CFR_DIR];
		end
	end

	// Command and address control readback.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			aluCmd_q <= `CFR_CMD_RST;
			eaCtrl_q <= `CFR_CMD_RST;
		end else begin
			if (wrAlu)
				aluCmd_q <= pwdata;
			if (wrEa)
				eaCtrl_q <= pwdata;
		end
	end

	// ----------------------------------------
	// Read mux and bus answer.
	// ----------------------------------------
	always @* begin
		rdData = `CFR_CMD_RST;
		if (gprHit) begin
			rdData = {16'h0000, gprWord(gprAll, gprIdx)};
		end else if (segHit) begin
			rdData = {16'h0000, segAll[segIdx*DW +: DW]};
		end else begin
			case (paddr)
				`CFR_OFF_IP: rdData = {16'h0000, ip_q};
				`CFR_OFF_FLAGS: rdData = {16'h0000, flags_q & `CFR_FLAGS_MASK};
				`CFR_OFF_ALU: rdData = aluCmd_q;
				`CFR_OFF_EA: rdData = eaCtrl_q;
				`CFR_OFF_EAOFF: rdData = {16'h0000, eaOff};
				`CFR_OFF_PHYS: rdData = {12'h000, physAddr};
				default: rdData = `CFR_CMD_RST;
			endcase
		end
	end

	// Read data is captured in the setup cycle; the address is stable until done.
	always @(posedge clk_sys) begin
		if (!nrst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= `CFR_CMD_RST;
		end else begin
			pready_q <= apbSetup;
			pslverr_q <= apbSetup & ~mapped;
			if (apbSetup)
				prdata_q <= mapped ? rdData : `CFR_CMD_RST;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign intAccept = intAccept_q;
	assign stepTrap = stepTrap_q;
	assign stringDown = stringDown_q;
endmodule // cfr_core
`default_nettype wire

// file: cfr_regs.vh
// cfr_regs.vh: register map, flag positions, command fields and codes.
// Assumes it is included by every core file; it holds definitions only.
`ifndef CFR_REGS_VH
`define CFR_REGS_VH
// ----------------------------------------
// Register byte offsets.
// ----------------------------------------
`define CFR_OFF_GPR 8'h00
`define CFR_OFF_SEG 8'h20
`define CFR_OFF_IP 8'h30
`define CFR_OFF_FLAGS 8'h34
`define CFR_OFF_ALU 8'h38
`define CFR_OFF_EA 8'h3C
`define CFR_OFF_EAOFF 8'h40
`define CFR_OFF_PHYS 8'h44
`define CFR_OFF_STR 8'h48
`define CFR_OFF_ADV 8'h4C
`define CFR_OFF_LAST 8'h4C
`define CFR_ALIGN 2'b00
// ----------------------------------------
// Status word bits, mask and reset values.
// ----------------------------------------
`define CFR_CARRY 0
`define CFR_PARITY 2
`define CFR_AUXC 4
`define CFR_ZERO 6
`define CFR_SIGN 7
`define CFR_STEP 8
`define CFR_INTEN 9
`define CFR_DIR 10
`define CFR_OVFL 11
`define CFR_FLAGS_MASK 16'h0FD5
`define CFR_FLAGS_RST 16'h0000
`define CFR_REG_RST 16'h0000
`define CFR_CMD_RST 32'h0000_0000
// ----------------------------------------
// Command fields, byte register index, widths.
// ----------------------------------------
`define CFR_F_OPC 3:0
`define CFR_F_DST 6:4
`define CFR_F_SRC 10:8
`define CFR_F_BYTE 12
`define CFR_F_EAMODE 2:0
`define CFR_F_EASEG 5:4
`define CFR_F_DISP 31:16
`define CFR_F_SWORD 0
`define CFR_F_LEN 3:0
`define CFR_BR_HI 2
`define CFR_BR_WORD 1:0
`define CFR_BYTE_MSB 7
`define CFR_WORD_MSB 15
`define CFR_BYTE_W 8
`define CFR_NIB_W 4
`define CFR_WORD_W 16
// ----------------------------------------
// Operation codes, register indices, address modes.
// ----------------------------------------
`define CFR_OP_ADD 4'h0
`define CFR_OP_ADC 4'h1
`define CFR_OP_SUB 4'h2
`define CFR_OP_SBB 4'h3
`define CFR_OP_AND 4'h4
`define CFR_OP_OR 4'h5
`define CFR_OP_XOR 4'h6
`define CFR_OP_CMP 4'h7
`define CFR_OP_MOV 4'h8
`define CFR_OP_INC 4'h9
`define CFR_OP_DEC 4'hA
`define CFR_R_BASE 3'h3
`define CFR_R_BPTR 3'h5
`define CFR_R_SIDX 3'h6
`define CFR_R_DIDX 3'h7
`define CFR_EA_BSI 3'h0
`define CFR_EA_BDI 3'h1
`define CFR_EA_PSI 3'h2
`define CFR_EA_PDI 3'h3
`define CFR_EA_SI 3'h4
`define CFR_EA_DI 3'h5
`define CFR_EA_DISP 3'h6
`define CFR_EA_B 3'h7
`define CFR_STEP_BYTE 16'h0001
`define CFR_STEP_WORD 16'h0002
`define CFR_ONE16 16'h0001
`define CFR_SEG_PAD 4'h0
`define CFR_LEN_PAD 12'h000
`endif

// file: cfr_flag_unit.v
// cfr_flag_unit.v: combinational arithmetic and logic unit with result flags.
// Assumes operands are already byte-selected and zero-extended in byte mode.
`timescale 1ns/1ps
`default_nettype none
`include "cfr_regs.vh"
module cfr_flag_unit (
	// Operands and operation.
	input wire [15:0] opA,
	input wire [15:0] opB,
	input wire carryIn,
	input wire [3:0] opCode,
	input wire byteMode,
	// Result and flags.
	output reg [15:0] result,
	output reg carryOut,
	output reg parityOut,
	output reg auxOut,
	output reg zeroOut,
	output reg signOut,
	output reg ovflOut,
	output reg updFlags,
	output reg keepCarry,
	output reg writeBack
);
	reg subtract;
	reg isArith;
	reg cin;
	reg [15:0] bOp;
	reg [16:0] sum;
	reg [8:0] lowSum;
	reg [4:0] nibSum;
	reg carry;
	reg msbA;
	reg msbB;

	// Subtraction runs as an add of the inverted operand, so borrow is carry inverted.
	always @* begin
		subtract = 1'b0;
		isArith = 1'b1;
		cin = 1'b0;
		bOp = opB;
		keepCarry = 1'b0;
		writeBack = 1'b1;
		updFlags = 1'b1;
		case (opCode)
			`CFR_OP_ADD: cin = 1'b0;
			`CFR_OP_ADC: cin = carryIn;
			`CFR_OP_SUB: subtract = 1'b1;
			`CFR_OP_SBB: subtract = 1'b1;
			`CFR_OP_CMP: begin
				subtract = 1'b1;
				writeBack = 1'b0;
			end
			`CFR_OP_INC: begin
				bOp = `CFR_ONE16;
				keepCarry = 1'b1;
			end
			`CFR_OP_DEC: begin
				bOp = `CFR_ONE16;
				subtract = 1'b1;
				keepCarry = 1'b1;
			end
			`CFR_OP_MOV: begin
				isArith = 1'b0;
				updFlags = 1'b0;
			end
			default: isArith = 1'b0;
		endcase
		if (subtract) begin
			bOp = ~bOp;
			cin = (opCode == `CFR_OP_SBB) ? ~carryIn : 1'b1;
		end
		sum = {1'b0, opA} + {1'b0, bOp} + {16'h0000, cin};
		lowSum = {1'b0, opA[7:0]} + {1'b0, bOp[7:0]} + {8'h00, cin};
		nibSum = {1'b0, opA[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cin};
		case (opCode)
			`CFR_OP_AND: result = opA & opB;
			`CFR_OP_OR: result = opA | opB;
			`CFR_OP_XOR: result = opA ^ opB;
			`CFR_OP_MOV: result = opB;
			default: result = sum[15:0];
		endcase
		if (byteMode)
			result = {8'h00, result[7:0]};
		carry = byteMode ? lowSum[`CFR_BYTE_W] : sum[`CFR_WORD_W];
		carryOut = isArith & (carry ^ subtract);
		auxOut = isArith & (nibSum[`CFR_NIB_W] ^ subtract);
		signOut = byteMode ? result[`CFR_BYTE_MSB] : result[`CFR_WORD_MSB];
		msbA = byteMode ? opA[`CFR_BYTE_MSB] : opA[`CFR_WORD_MSB];
		msbB = byteMode ? bOp[`CFR_BYTE_MSB] : bOp[`CFR_WORD_MSB];
		ovflOut = isArith & (msbA == msbB) & (signOut != msbA);
		zeroOut = (result == 16'h0000);
		parityOut = ~^result[7:0];
	end
endmodule // cfr_flag_unit
`default_nettype wire

// file: cfr_gpr_file.v
// cfr_gpr_file.v: general register storage with byte-lane and second word port.
// Assumes the two write ports never name the same entry in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "cfr_regs.vh"
module cfr_gpr_file #(
	parameter DW = 16,
	parameter NREG = 8,
	parameter IW = 3
) (
	// Clock and reset.
	input wire clk_sys,
	input wire nrst,
	// Port A, with byte lanes.
	input wire aEn,
	input wire [IW-1:0] aIdx,
	input wire aLo,
	input wire aHi,
	input wire [DW-1:0] aData,
	// Port B, whole word.
	input wire bEn,
	input wire [IW-1:0] bIdx,
	input wire [DW-1:0] bData,
	// All entries, flattened.
	output wire [NREG*DW-1:0] rdAll
);
	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : gEnt
			reg [DW-1:0] ent_q;
			always @(posedge clk_sys) begin
				if (!nrst) begin
					ent_q <= `CFR_REG_RST;
				end else if (aEn && {{(32-IW){1'b0}}, aIdx} == g) begin
					if (aLo)
						ent_q[DW/2-1:0] <= aData[DW/2-1:0];
					if (aHi)
						ent_q[DW-1:DW/2] <= aData[DW-1:DW/2];
				end else if (bEn && {{(32-IW){1'b0}}, bIdx} == g) begin
					ent_q <= bData;
				end
			end
			assign rdAll[g*DW +: DW] = ent_q;
		end
	endgenerate
endmodule // cfr_gpr_file
`default_nettype wire

// file: cfr_core_properties.sv
// cfr_core_properties.sv: concurrent checks on the ports of cfr_core.
// Assumes a bind to cfr_core; it sees the top ports and nothing inside.
`timescale 1ns/1ps
`default_nettype none
module cfr_core_properties #(
	parameter DW = 16,
	parameter NGPR = 8,
	parameter NSEG = 4
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic nrst,
	// Register bus.
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Interrupt and core events.
	input wire logic intReq,
	input wire logic intAccept,
	input wire logic stepTrap,
	input wire logic stringDown
);
	// ----------------
	// Control flag copy
	// ----------------
	logic wrDone;
	logic trapQ;
	logic enQ;
	logic downQ;
	// Control bits change only by status writes and by the trap, so this copy stays exact.
	assign wrDone = psel && penable && pready && pwrite;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			trapQ <= 1'b0;
			enQ <= 1'b0;
			downQ <= 1'b0;
		end else if (wrDone && paddr == 8'h34) begin
			{downQ, enQ, trapQ} <= pwdata[10:8];
		end else if (wrDone && paddr == 8'h4C) begin
			trapQ <= 1'b0;
		end
	end
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	bus_ready_a: assert property (pready == $past(psel && !penable))
		else $error("ready not one cycle after setup");
	bad_address_a: assert property (pready && (paddr[1:0] != 2'b00 || paddr > 8'h4C) |-> pslverr && (pwrite || prdata == 0))
		else $error("unmapped access not refused");
	status_bits_a: assert property (pready && !pwrite && paddr == 8'h34 |->
		(prdata & 32'hFFFF_F02A) == 0 && prdata[10:8] == {downQ, enQ, trapQ})
		else $error("status readback wrong");
	trap_raise_a: assert property (wrDone && paddr == 8'h4C && trapQ |=> stepTrap)
		else $error("single step trap missing");
	trap_cause_a: assert property (stepTrap |-> $past(wrDone && paddr == 8'h4C && trapQ))
		else $error("trap without cause");
	int_masked_a: assert property (!enQ |=> !intAccept)
		else $error("interrupt taken while disabled");
	int_take_a: assert property (intReq && enQ && !wrDone && !intAccept |=> intAccept)
		else $error("enabled interrupt not taken");
	dir_follow_a: assert property (stringDown == $past(downQ))
		else $error("direction output wrong");
	cover property (stepTrap);
	cover property (intAccept);
	cover property (pready && pslverr);
endmodule // cfr_core_properties
bind cfr_core cfr_core_properties #(.DW(DW), .NGPR(NGPR), .NSEG(NSEG)) chk (.clk_sys(clk_sys), .nrst(nrst),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .intReq(intReq), .intAccept(intAccept), .stepTrap(stepTrap),
	.stringDown(stringDown));
`default_nettype wire

// file: cpu_flags_and_registers_test.sv
// cpu_flags_and_registers_test.sv: self-checking bench for cfr_core.
// Assumes the design and its checker are compiled first; the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none
module cpu_flags_and_registers_test;
	// ----------------
	// Signals and model state
	// ----------------
	logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, intReq = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [15:0] intVector = 16'h0000;
	wire [31:0] prdata;
	wire pready, pslverr, intAccept, stepTrap, stringDown;
	logic [31:0] rd;
	logic err;
	int failures = 0, samples_checked = 0, accepts = 0, traps = 0, ip = 0, fl = 0;
	int gpr[8], seg[4];
	cfr_core uut (.clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .intReq(intReq),
		.intVector(intVector), .intAccept(intAccept), .stepTrap(stepTrap), .stringDown(stringDown));
	// The clock toggles every 12.5 ns, half of its 25 ns period.
	always #12.5 clk_sys = ~clk_sys;
	// Pulses are counted here, so a one-cycle pulse is never missed by a busy task.
	always @(posedge clk_sys) begin
		if (intAccept === 1'b1) accepts++;
		if (stepTrap === 1'b1) traps++;
	end
	// ----------------
	// Tasks and model
	// ----------------
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// One transfer; the request is held until ready is sampled high, then released.
	task automatic apb(input int a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= 8'(a);
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failures++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input string what, input int a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0000_0000);
		check(what, exp, rd);
	endtask
	// Corner values are favoured, since sign and carry edges hide there.
	function automatic int pick();
		int corner[4] = '{0, 16'h7FFF, 16'h8000, 16'hFFFF};
		return $urandom % 3 == 0 ? corner[$urandom % 4] : $urandom % 65536;
	endfunction
	function automatic int getr(input int c, input int bm);
		if (bm == 0) return gpr[c];
		return c > 3 ? gpr[c - 4] >> 8 : gpr[c] & 255;
	endfunction
	function automatic void setr(input int c, input int bm, input int v);
		if (bm == 0) gpr[c] = v;
		else if (c > 3) gpr[c - 4] = gpr[c - 4] & 255 | v << 8;
		else gpr[c] = gpr[c] & 16'hFF00 | v;
	endfunction
	function automatic void alu(input int op, input int a, input int b, input int bm, output int r);
		int w, hb, cy, hc, ov;
		w = bm ? 8 : 16;
		hb = 1 << (w - 1);
		if (op > 8) b = 1;
		if (op == 8) r = b;
		else if (op == 4) r = a & b;
		else if (op == 5) r = a | b;
		else if (op == 6) r = a ^ b;
		else if (op < 2 || op == 9) r = a + b + (op == 1 ? fl & 1 : 0);
		else r = a - b - (op == 3 ? fl & 1 : 0);
		cy = op > 8 ? fl & 1 : (r >> w) & 1;
		hc = (a ^ b ^ r) >> 4 & 1;
		ov = ((op < 2 || op == 9 ? ~(a ^ b) : a ^ b) & (a ^ r) & hb) != 0;
		if (op > 3 && op < 7) {cy, hc, ov} = 0;
		r = r & (hb * 2 - 1);
		if (op != 8) fl = fl & 16'h0700 | cy | (^r[7:0] ? 0 : 4) | hc << 4 | (r == 0 ? 16'h0040 : 0)
			| ((r & hb) != 0 ? 16'h0080 : 0) | ov << 11;
	endfunction
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		int i, op, d, s, r, bm, a, b, o, t;
		r = $urandom(32'hd633);
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		for (i = 0; i < 14; i++) rdchk("reset word", i * 4, 0);
		apb(8'h50, 1'b1, 32'hFFFF_FFFF);
		check("unmapped error", 1, err);
		apb(8'h06, 1'b0, 0);
		check("unaligned error", 1, err);
		// Upper write bits are junk and must be dropped.
		for (i = 0; i < 12; i++) begin
			r = pick();
			if (i < 8) gpr[i] = r;
			else seg[i - 8] = r;
			apb(i * 4, 1'b1, {16'($urandom), 16'(r)});
			rdchk("stored word", i * 4, r);
		end
		for (i = 0; i < 66; i++) begin
			op = i % 11;
			d = $urandom % 8;
			s = $urandom % 8;
			bm = $urandom % 2;
			r = pick();
			gpr[bm ? d % 4 : d] = r;
			apb((bm ? d % 4 : d) * 4, 1'b1, r);
			r = pick();
			gpr[bm ? s % 4 : s] = r;
			apb((bm ? s % 4 : s) * 4, 1'b1, r);
			r = $urandom % 65536;
			fl = r & 16'h0FD5;
			apb(8'h34, 1'b1, r);
			a = getr(d, bm);
			b = getr(s, bm);
			alu(op, a, b, bm, r);
			if (op != 7) setr(d, bm, r);
			apb(8'h38, 1'b1, op | d << 4 | s << 8 | bm << 12);
			rdchk("result word", (bm ? d % 4 : d) * 4, gpr[bm ? d % 4 : d]);
			rdchk("status word", 8'h34, fl);
		end
		rdchk("command word", 8'h38, op | d << 4 | s << 8 | bm << 12);
		for (i = 0; i < 8; i++) begin
			b = i == 6 ? $urandom % 65536 : 0;
			apb(8'h3C, 1'b1, i | (i % 4) << 4 | b << 16);
			o = (b + (i < 4 || i == 7 ? gpr[i < 2 || i == 7 ? 3 : 5] : 0) + (i < 6 ? gpr[6 + i % 2] : 0)) % 65536;
			rdchk("offset", 8'h40, o);
			rdchk("physical address", 8'h44, (seg[i % 4] * 16 + o) & 32'h000F_FFFF);
			rdchk("address control", 8'h3C, i | (i % 4) << 4 | b << 16);
		end
		for (i = 0; i < 4; i++) begin
			apb(8'h34, 1'b1, i / 2 * 16'h0400);
			apb(8'h48, 1'b1, i % 2);
			t = (i % 2 + 1) * (i < 2 ? 1 : -1);
			gpr[6] = (gpr[6] + t) & 16'hFFFF;
			gpr[7] = (gpr[7] + t) & 16'hFFFF;
			check("direction output", i / 2, stringDown);
			rdchk("source index", 8'h18, gpr[6]);
			rdchk("target index", 8'h1C, gpr[7]);
		end
		for (i = 0; i < 2; i++) begin
			t = traps;
			apb(8'h34, 1'b1, (1 - i) * 16'h0100);
			apb(8'h4C, 1'b1, 15 - i * 10);
			ip = (ip + 15 - i * 10) & 16'hFFFF;
			rdchk("pointer", 8'h30, ip);
			check("trap pulses", t + 1 - i, traps);
			rdchk("status after step", 8'h34, 0);
		end
		rdchk("step strobe read", 8'h4C, 0);
		// A masked request must stay unseen; once enabled it is dropped on acceptance.
		t = accepts;
		intVector <= 16'($urandom);
		intReq <= 1'b1;
		repeat (8) @(posedge clk_sys);
		check("masked accepts", t, accepts);
		apb(8'h34, 1'b1, 16'h0200);
		for (i = 0; i < 20 && intAccept !== 1'b1; i++) @(posedge clk_sys);
		if (intAccept !== 1'b1) begin
			failures++;
			test_done();
		end
		intReq <= 1'b0;
		rdchk("vector pointer", 8'h30, intVector);
		check("accepts", t + 1, accepts);
		rdchk("status kept", 8'h34, 16'h0200);
		test_done();
	end
endmodule // cpu_flags_and_registers_test
`default_nettype wire
